// [hdl/pof_consts.svh]
`ifndef POF_CONSTS_SVH
`define POF_CONSTS_SVH

// channel count and config bundle width
`define POF_NCH          8
`define POF_CFG_W        89

// register addresses
`define POF_ADDR_CAL     8'h80
`define POF_ADDR_FMT     8'h81
`define POF_ADDR_IDLE    8'h82
`define POF_ADDR_FRAME   8'h83
`define POF_ADDR_DARK    8'h84
`define POF_ADDR_IMG     8'h85
`define POF_ADDR_CRC     8'h86
`define POF_ADDR_IDMK    8'h87
`define POF_ADDR_FAULT   8'h88
`define POF_ADDR_RSVD    8'h89

// reset values
`define POF_RST_CAL      16'h4008
`define POF_RST_FMT      16'hC001
`define POF_RST_IDLE     10'h3A6
`define POF_RST_FRAME    7'h2A
`define POF_RST_DARK     10'h015
`define POF_RST_IMG      10'h035
`define POF_RST_CRC      10'h059
`define POF_RST_IDMK     10'h3A6

// output format control fields
`define POF_FMT_AUTO     0
`define POF_FMT_OFF_LO   1
`define POF_FMT_OFF_HI   9
`define POF_FMT_SUB      10
`define POF_FMT_NARROW   13
`define POF_FMT_FQ       14
`define POF_FMT_LQ       15

// calibration control fields
`define POF_CAL_TGT_HI   7
`define POF_CAL_N_LO     8
`define POF_CAL_N_HI     10

// frame marker top bits: frame/line, start, end
`define POF_SYNC_FS      3'h6
`define POF_SYNC_FE      3'h5
`define POF_SYNC_LS      3'h2
`define POF_SYNC_LE      3'h1

`endif

// [hdl/pof_pkg.sv]
`default_nettype none

package pof_pkg;
	// word kind presented by the sensor core each link cycle
	typedef enum logic [2:0] {
		K_IDLE,
		K_FS,
		K_FE,
		K_LS,
		K_LE,
		K_DARK,
		K_IMG,
		K_CRC
	} pof_kind_t;
endpackage

`default_nettype wire

// [hdl/pof_dark_chan.sv]
`timescale 1ns/10ps
`default_nettype none

module pof_dark_chan (
	// clock and reset
	input  wire logic       lclk,
	input  wire logic       rst,
	// slot strobes
	input  wire logic       frame_start,
	input  wire logic       dark_in,
	input  wire logic       img_in,
	input  wire logic [9:0] pix_in,
	// configuration
	input  wire logic       auto_en,
	input  wire logic [8:0] man_off,
	input  wire logic       man_sub,
	input  wire logic       narrow,
	input  wire logic [7:0] target,
	input  wire logic [2:0] samp_log,
	// results
	output logic      [9:0] pix_out,
	output logic            fault
);

	logic        [16:0] sum_reg;
	logic        [7:0]  cnt_reg;
	logic               done_reg;
	logic signed [10:0] corr_reg;
	logic        [7:0]  need;
	logic        [9:0]  level;
	logic signed [10:0] man_corr;
	logic signed [11:0] sum_w;
	logic        [9:0]  clamp_w;

	assign need  = 8'h01 << samp_log;
	assign level = 10'(sum_reg >> samp_log);

	////////////////////////////////////////////////////////////////////////
	// dark sample accumulation, per frame
	always_ff @(posedge lclk or posedge rst) begin
		if (rst) begin
			sum_reg <= 17'h00000;
			cnt_reg <= 8'h00;
		end else if (frame_start) begin
			sum_reg <= 17'h00000;
			cnt_reg <= 8'h00;
		end else if (dark_in && !done_reg && cnt_reg < need) begin
			sum_reg <= sum_reg + {7'h00, pix_in};
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	// correction latched at first image word; short sample keeps old value
	always_ff @(posedge lclk or posedge rst) begin
		if (rst) begin
			done_reg <= 1'b0;
			fault    <= 1'b0;
			corr_reg <= 11'sh000;
		end else if (frame_start) begin
			done_reg <= 1'b0;
		end else if (img_in && !done_reg) begin
			done_reg <= 1'b1;
			if (cnt_reg < need) begin
				fault <= 1'b1;
			end else begin
				fault    <= 1'b0;
				corr_reg <= $signed({3'b000, target}) - $signed({1'b0, level});
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// offset, clamp and width
	assign man_corr = man_sub ? -$signed({2'b00, man_off}) : $signed({2'b00, man_off});

	always_comb begin
		if (auto_en) begin
			sum_w = $signed({2'b00, pix_in}) + {corr_reg[10], corr_reg};
		end else begin
			sum_w = $signed({2'b00, pix_in}) + {man_corr[10], man_corr};
		end
		if (sum_w < 12'sh000) begin
			clamp_w = 10'h000;
		end else if (sum_w > 12'sh3FF) begin
			clamp_w = 10'h3FF;
		end else begin
			clamp_w = sum_w[9:0];
		end
	end

	always_ff @(posedge lclk or posedge rst) begin
		if (rst) begin
			pix_out <= 10'h000;
		end else if (narrow) begin
			pix_out <= {2'b00, clamp_w[9:2]};
		end else begin
			pix_out <= clamp_w;
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_manual_add;
		@(posedge lclk) disable iff (rst)
		(!auto_en && !man_sub && !narrow && ({2'b00, pix_in} + {3'b000, man_off}) < 12'h400)
			|=> pix_out == 10'($past(pix_in) + {1'b0, $past(man_off)});
	endproperty
	a_manual_add: assert property (p_manual_add) else $error("manual add wrong");

	property p_manual_sub;
		@(posedge lclk) disable iff (rst)
		(!auto_en && man_sub && !narrow && pix_in >= {1'b0, man_off})
			|=> pix_out == 10'($past(pix_in) - {1'b0, $past(man_off)});
	endproperty
	a_manual_sub: assert property (p_manual_sub) else $error("manual subtract wrong");

	property p_narrow;
		@(posedge lclk) disable iff (rst)
		narrow |=> pix_out[9:8] == 2'b00;
	endproperty
	a_narrow: assert property (p_narrow) else $error("narrow word has top bits");

	property p_fault_set;
		@(posedge lclk) disable iff (rst)
		(img_in && !done_reg && !frame_start && cnt_reg < need) |=> fault;
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault flag not set");

	property p_fault_clr;
		@(posedge lclk) disable iff (rst)
		(img_in && !done_reg && !frame_start && cnt_reg >= need) |=> !fault ##1 done_reg;
	endproperty
	a_fault_clr: assert property (p_fault_clr) else $error("fault flag not cleared");

endmodule // pof_dark_chan

`default_nettype wire

// [hdl/pof_formatter.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pof_consts.svh"

module pof_formatter (
	// control clock domain
	input  wire logic                          mclk,
	input  wire logic                          rst,
	input  wire logic                          ce,
	// register port
	input  wire logic [7:0]                    reg_addr,
	input  wire logic [15:0]                   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [15:0]                   reg_rdata,
	// sensor core stream, link clock
	input  wire logic                          lclk,
	input  wire logic [2:0]                    pix_kind,
	input  wire logic                          pix_dark_row,
	input  wire logic [`POF_NCH-1:0][9:0]      pix_data,
	// link outputs
	output logic      [`POF_NCH-1:0][9:0]      lane_data,
	output logic      [9:0]                    sync_word,
	output logic                               frame_qual,
	output logic                               line_qual
);

	// control side registers
	logic [15:0]            cal_reg;
	logic [15:0]            fmt_reg;
	logic [9:0]             idle_reg;
	logic [6:0]             fcode_reg;
	logic [9:0]             darkc_reg;
	logic [9:0]             imgc_reg;
	logic [9:0]             crcc_reg;
	logic [9:0]             idmk_reg;
	logic [`POF_CFG_W-1:0]  cfg_live;
	// crossing, control side
	logic [`POF_CFG_W-1:0]  cfg_snap_reg;
	logic                   cfg_pend_reg;
	logic                   cfg_busy_reg;
	logic                   cfg_req_reg;
	logic [2:0]             ack_sync_reg;
	logic [`POF_NCH-1:0]    flt1_reg;
	logic [`POF_NCH-1:0]    flt2_reg;
	logic [`POF_NCH-1:0]    flt3_reg;
	logic [`POF_NCH-1:0]    fault_m_reg;
	// crossing, link side
	logic [2:0]             req_sync_reg;
	logic                   ack_l_reg;
	logic [`POF_CFG_W-1:0]  cfg_l_reg;
	logic [15:0]            cal_l;
	logic [15:0]            fmt_l;
	logic [9:0]             train_l;
	logic [6:0]             fcode_l;
	logic [9:0]             darkc_l;
	logic [9:0]             imgc_l;
	logic [9:0]             crcc_l;
	logic [9:0]             idmk_l;
	// link datapath
	pof_pkg::pof_kind_t     kind_d_reg;
	logic                   dark_d_reg;
	logic [`POF_NCH-1:0][9:0] raw_d_reg;
	logic [`POF_NCH-1:0][9:0] pix_c;
	logic [`POF_NCH-1:0]    fault_l;
	logic                   fa_reg;
	logic                   la_reg;
	logic                   frame_act;
	logic                   line_act;
	logic                   wr_hit;

	assign cfg_live = {cal_reg, fmt_reg, idle_reg, fcode_reg, darkc_reg, imgc_reg, crcc_reg,
		idmk_reg};
	// reset image of the config word, also the link side's starting copy
	localparam logic [`POF_CFG_W-1:0] cfg_rst = {`POF_RST_CAL, `POF_RST_FMT, `POF_RST_IDLE,
		`POF_RST_FRAME, `POF_RST_DARK, `POF_RST_IMG, `POF_RST_CRC, `POF_RST_IDMK};
	assign wr_hit   = ce && reg_wr;

	////////////////////////////////////////////////////////////////////////
	// register storage
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cal_reg   <= `POF_RST_CAL;
			fmt_reg   <= `POF_RST_FMT;
			idle_reg  <= `POF_RST_IDLE;
			fcode_reg <= `POF_RST_FRAME;
			darkc_reg <= `POF_RST_DARK;
			imgc_reg  <= `POF_RST_IMG;
			crcc_reg  <= `POF_RST_CRC;
			idmk_reg  <= `POF_RST_IDMK;
		end else if (wr_hit) begin
			case (reg_addr)
				`POF_ADDR_CAL:   cal_reg   <= reg_wdata;
				`POF_ADDR_FMT:   fmt_reg   <= reg_wdata;
				`POF_ADDR_IDLE:  idle_reg  <= reg_wdata[9:0];
				`POF_ADDR_FRAME: fcode_reg <= reg_wdata[6:0];
				`POF_ADDR_DARK:  darkc_reg <= reg_wdata[9:0];
				`POF_ADDR_IMG:   imgc_reg  <= reg_wdata[9:0];
				`POF_ADDR_CRC:   crcc_reg  <= reg_wdata[9:0];
				`POF_ADDR_IDMK:  idmk_reg  <= reg_wdata[9:0];
				default: ;
			endcase
		end
	end

	// read data held until the next read
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (ce && reg_rd) begin
			case (reg_addr)
				`POF_ADDR_CAL:   reg_rdata <= cal_reg;
				`POF_ADDR_FMT:   reg_rdata <= fmt_reg;
				`POF_ADDR_IDLE:  reg_rdata <= {6'h00, idle_reg};
				`POF_ADDR_FRAME: reg_rdata <= {9'h000, fcode_reg};
				`POF_ADDR_DARK:  reg_rdata <= {6'h00, darkc_reg};
				`POF_ADDR_IMG:   reg_rdata <= {6'h00, imgc_reg};
				`POF_ADDR_CRC:   reg_rdata <= {6'h00, crcc_reg};
				`POF_ADDR_IDMK:  reg_rdata <= {6'h00, idmk_reg};
				`POF_ADDR_FAULT: reg_rdata <= {8'h00, fault_m_reg};
				default:         reg_rdata <= 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// config word handshake to the link side; snapshot held while busy
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_snap_reg <= cfg_rst;
			cfg_pend_reg <= 1'b0;
			cfg_busy_reg <= 1'b0;
			cfg_req_reg  <= 1'b0;
			ack_sync_reg <= 3'h0;
		end else if (ce) begin
			ack_sync_reg <= {ack_sync_reg[1:0], ack_l_reg};
			if (cfg_pend_reg && !cfg_busy_reg) begin
				cfg_snap_reg <= cfg_live;
				cfg_req_reg  <= ~cfg_req_reg;
				cfg_busy_reg <= 1'b1;
				// a write in the launch cycle stays pending
				cfg_pend_reg <= wr_hit;
			end else begin
				if (wr_hit) begin
					cfg_pend_reg <= 1'b1;
				end
				if (cfg_busy_reg && ack_sync_reg[1] == ack_sync_reg[2]
						&& ack_sync_reg[2] == cfg_req_reg) begin
					cfg_busy_reg <= 1'b0;
				end
			end
		end
	end

	// fault flags are independent levels; each bit settles on its own
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			flt1_reg    <= '0;
			flt2_reg    <= '0;
			flt3_reg    <= '0;
			fault_m_reg <= '0;
		end else if (ce) begin
			flt1_reg    <= fault_l;
			flt2_reg    <= flt1_reg;
			flt3_reg    <= flt2_reg;
			fault_m_reg <= (~(flt2_reg ^ flt3_reg) & flt3_reg)
				| ((flt2_reg ^ flt3_reg) & fault_m_reg);
		end
	end

	always_ff @(posedge lclk or posedge rst) begin
		if (rst) begin
			req_sync_reg <= 3'h0;
			ack_l_reg    <= 1'b0;
			cfg_l_reg    <= cfg_rst;
		end else begin
			req_sync_reg <= {req_sync_reg[1:0], cfg_req_reg};
			if (req_sync_reg[1] == req_sync_reg[2] && req_sync_reg[2] != ack_l_reg) begin
				cfg_l_reg <= cfg_snap_reg;
				ack_l_reg <= req_sync_reg[2];
			end
		end
	end

	assign {cal_l, fmt_l, train_l, fcode_l, darkc_l, imgc_l, crcc_l, idmk_l} = cfg_l_reg;

	////////////////////////////////////////////////////////////////////////
	// per-channel correction, one slot of latency
	genvar gi;
	generate
		for (gi = 0; gi < `POF_NCH; gi = gi + 1) begin : g_chan
			pof_dark_chan u_chan (
				.lclk        (lclk),
				.rst         (rst),
				.frame_start (pix_kind == pof_pkg::K_FS),
				.dark_in     (pix_kind == pof_pkg::K_DARK),
				.img_in      (pix_kind == pof_pkg::K_IMG),
				.pix_in      (pix_data[gi]),
				.auto_en     (fmt_l[`POF_FMT_AUTO]),
				.man_off     (fmt_l[`POF_FMT_OFF_HI:`POF_FMT_OFF_LO]),
				.man_sub     (fmt_l[`POF_FMT_SUB]),
				.narrow      (fmt_l[`POF_FMT_NARROW]),
				.target      (cal_l[`POF_CAL_TGT_HI:0]),
				.samp_log    (cal_l[`POF_CAL_N_HI:`POF_CAL_N_LO]),
				.pix_out     (pix_c[gi]),
				.fault       (fault_l[gi])
			);
		end
	endgenerate

	// kind and raw words delayed to meet the corrected words
	always_ff @(posedge lclk or posedge rst) begin
		if (rst) begin
			kind_d_reg <= pof_pkg::K_IDLE;
			dark_d_reg <= 1'b0;
			raw_d_reg  <= '0;
		end else begin
			kind_d_reg <= pof_pkg::pof_kind_t'(pix_kind);
			dark_d_reg <= pix_dark_row;
			raw_d_reg  <= pix_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// lane and sync words leave together
	always_ff @(posedge lclk or posedge rst) begin
		if (rst) begin
			lane_data <= {`POF_NCH{`POF_RST_IDLE}};
			sync_word <= `POF_RST_IDMK;
		end else begin
			case (kind_d_reg)
				pof_pkg::K_DARK: begin
					lane_data <= pix_c;
					sync_word <= darkc_l;
				end
				pof_pkg::K_IMG: begin
					lane_data <= pix_c;
					sync_word <= imgc_l;
				end
				pof_pkg::K_CRC: begin
					lane_data <= raw_d_reg;
					sync_word <= crcc_l;
				end
				pof_pkg::K_FS: begin
					lane_data <= {`POF_NCH{train_l}};
					sync_word <= {`POF_SYNC_FS, fcode_l};
				end
				pof_pkg::K_FE: begin
					lane_data <= {`POF_NCH{train_l}};
					sync_word <= {`POF_SYNC_FE, fcode_l};
				end
				pof_pkg::K_LS: begin
					lane_data <= {`POF_NCH{train_l}};
					sync_word <= {`POF_SYNC_LS, fcode_l};
				end
				pof_pkg::K_LE: begin
					lane_data <= {`POF_NCH{train_l}};
					sync_word <= {`POF_SYNC_LE, fcode_l};
				end
				default: begin
					// receiver aligns each lane on this word
					lane_data <= {`POF_NCH{train_l}};
					sync_word <= idmk_l;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// qualifiers for the parallel variant, start and end slots included
	assign frame_act = (kind_d_reg == pof_pkg::K_FS) || fa_reg;
	assign line_act  = (kind_d_reg == pof_pkg::K_LS) || la_reg;

	always_ff @(posedge lclk or posedge rst) begin
		if (rst) begin
			fa_reg     <= 1'b0;
			frame_qual <= 1'b0;
		end else begin
			if (kind_d_reg == pof_pkg::K_FS) begin
				fa_reg <= 1'b1;
			end else if (kind_d_reg == pof_pkg::K_FE) begin
				fa_reg <= 1'b0;
			end
			frame_qual <= frame_act && (!dark_d_reg || fmt_l[`POF_FMT_FQ]);
		end
	end

	always_ff @(posedge lclk or posedge rst) begin
		if (rst) begin
			la_reg    <= 1'b0;
			line_qual <= 1'b0;
		end else begin
			if (kind_d_reg == pof_pkg::K_LS) begin
				la_reg <= 1'b1;
			end else if (kind_d_reg == pof_pkg::K_LE) begin
				la_reg <= 1'b0;
			end
			line_qual <= line_act && (!dark_d_reg || fmt_l[`POF_FMT_LQ]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	sequence s_idle_in;
		pix_kind == pof_pkg::K_IDLE;
	endsequence

	property p_idle_lanes;
		@(posedge lclk) disable iff (rst)
		s_idle_in |-> ##2 (lane_data[0] == $past(train_l)
			&& lane_data[`POF_NCH-1] == $past(train_l) && sync_word == $past(idmk_l));
	endproperty
	a_idle_lanes: assert property (p_idle_lanes) else $error("idle word missing");

	property p_fs_mark;
		@(posedge lclk) disable iff (rst)
		pix_kind == pof_pkg::K_FS |-> ##2 sync_word == {3'h6, $past(fcode_l)};
	endproperty
	a_fs_mark: assert property (p_fs_mark) else $error("frame start code wrong");

	property p_le_mark;
		@(posedge lclk) disable iff (rst)
		pix_kind == pof_pkg::K_LE |-> ##2 sync_word == {3'h1, $past(fcode_l)};
	endproperty
	a_le_mark: assert property (p_le_mark) else $error("line end code wrong");

	property p_dark_mark;
		@(posedge lclk) disable iff (rst)
		pix_kind == pof_pkg::K_DARK |-> ##2 sync_word == $past(darkc_l);
	endproperty
	a_dark_mark: assert property (p_dark_mark) else $error("dark marker wrong");

	property p_crc_mark;
		@(posedge lclk) disable iff (rst)
		pix_kind == pof_pkg::K_CRC |-> ##2 (sync_word == $past(crcc_l)
			&& lane_data == $past(pix_data, 2));
	endproperty
	a_crc_mark: assert property (p_crc_mark) else $error("checksum marker wrong");

	property p_same_slot;
		@(posedge lclk) disable iff (rst)
		pix_kind == pof_pkg::K_IMG |-> ##2 (sync_word == $past(imgc_l)
			&& lane_data == $past(pix_c));
	endproperty
	a_same_slot: assert property (p_same_slot) else $error("marker and pixel split");

	property p_fq_gate;
		@(posedge lclk) disable iff (rst)
		(pix_dark_row && !fmt_l[`POF_FMT_FQ]) ##1 !fmt_l[`POF_FMT_FQ] |=> !frame_qual;
	endproperty
	a_fq_gate: assert property (p_fq_gate) else $error("frame qualifier on dark row");

	property p_lq_gate;
		@(posedge lclk) disable iff (rst)
		(pix_dark_row && !fmt_l[`POF_FMT_LQ]) ##1 !fmt_l[`POF_FMT_LQ] |=> !line_qual;
	endproperty
	a_lq_gate: assert property (p_lq_gate) else $error("line qualifier on dark row");

	property p_fault_read;
		@(posedge mclk) disable iff (rst)
		(ce && reg_rd && reg_addr == `POF_ADDR_FAULT) |=> reg_rdata == {8'h00, $past(fault_m_reg)};
	endproperty
	a_fault_read: assert property (p_fault_read) else $error("fault read wrong");

endmodule // pof_formatter

`default_nettype wire

// [verification/pof_receiver.sv]
`timescale 1ns/10ps
`default_nettype none

module pof_receiver (
	// link side
	input  wire logic            lclk,
	input  wire logic            rst,
	input  wire logic [7:0][9:0] lane_data,
	input  wire logic [9:0]      sync_word,
	// codes currently programmed
	input  wire logic [9:0]      idle_code,
	input  wire logic [9:0]      dark_code,
	input  wire logic [9:0]      img_code,
	input  wire logic [9:0]      crc_code,
	input  wire logic [6:0]      frame_code,
	// decoded word counts
	output int                   n_fs,
	output int                   n_dark,
	output int                   n_img,
	output int                   n_crc
);
	logic [2:0] run;
	logic       all_idle;

	always_comb begin
		all_idle = 1'b1;
		for (int i = 0; i < 8; i++) if (lane_data[i] !== idle_code) all_idle = 1'b0;
	end

	// once locked, stays locked: pixel data may mimic the idle word
	always_ff @(posedge lclk or posedge rst) begin
		if (rst) run <= 3'h0;
		else if (run != 3'h4) run <= all_idle ? run + 3'h1 : 3'h0;
	end

	always_ff @(posedge lclk or posedge rst) begin
		if (rst) begin
			n_fs <= 0;
			n_dark <= 0;
			n_img <= 0;
			n_crc <= 0;
		end else if (run == 3'h4) begin
			n_fs <= n_fs + int'(sync_word == {3'h6, frame_code});
			n_dark <= n_dark + int'(sync_word == dark_code);
			n_img <= n_img + int'(sync_word == img_code);
			n_crc <= n_crc + int'(sync_word == crc_code);
		end
	end
endmodule // pof_receiver

`default_nettype wire

// [verification/pixel_output_formatter_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pof_consts.svh"

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s exp=%h got=%h", nm, e, g); end end

module pixel_output_formatter_bench;
	logic            mclk, rst, ce, lclk, reg_wr, reg_rd, pix_dark_row, frame_qual, line_qual;
	logic [7:0]      reg_addr, flt;
	logic [15:0]     reg_wdata, reg_rdata, d;
	logic [2:0]      pix_kind;
	logic [1:0]      pv;
	logic [7:0][9:0] pix_data, lane_data;
	logic [9:0]      sync_word;
	logic [15:0]     sh [8'h80:8'h89];
	logic [91:0]     pe [0:1];
	logic            in_f, in_l, cal;
	int              n_mismatch, samples_checked, seed, n_fs, n_dark, n_img, n_crc;
	int              k_fs, k_dark, k_img, k_crc, cnt, sum [8], acor [8];

	initial begin mclk = 0; forever #10 mclk = ~mclk; end
	initial begin lclk = 0; #7; forever #24 lclk = ~lclk; end

	pof_formatter DUT (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.lclk(lclk), .pix_kind(pix_kind), .pix_dark_row(pix_dark_row), .pix_data(pix_data),
		.lane_data(lane_data), .sync_word(sync_word), .frame_qual(frame_qual),
		.line_qual(line_qual));
	pof_receiver RX (.lclk(lclk), .rst(rst), .lane_data(lane_data), .sync_word(sync_word),
		.idle_code(sh[8'h82][9:0]), .dark_code(sh[8'h84][9:0]), .img_code(sh[8'h85][9:0]),
		.crc_code(sh[8'h86][9:0]), .frame_code(sh[8'h83][6:0]), .n_fs(n_fs),
		.n_dark(n_dark), .n_img(n_img), .n_crc(n_crc));

	function automatic logic [15:0] rexp(input logic [7:0] a);
		return (a == 8'h88) ? {8'h00, flt} : (a < 8'h88) ? sh[a] : 16'h0000;
	endfunction

	task automatic reg_chk(input logic [7:0] a, input logic [15:0] e);
		@(posedge mclk); #1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge mclk); #1;
		reg_rd = 1'b0;
		`CHK("reg_rdata", e, reg_rdata)
	endtask

	// one link word; compares the word launched two slots back
	task automatic slot(input logic [2:0] k, input logic dr, input logic chk);
		logic [91:0] e;
		int          v, n;
		logic        cs;
		@(posedge lclk); #1;
		if (pv[1]) `CHK("link", pe[1], {frame_qual, line_qual, sync_word, lane_data})
		pe[1] = pe[0];
		pix_kind = k;
		pix_dark_row = dr;
		for (int i = 0; i < 8; i++) pix_data[i] = 10'($random(seed));
		n = int'(sh[8'h80][10:8]);
		if (k == 3'h1) begin
			cnt = 0;
			cal = 1'b0;
			sum = '{default:0};
		end
		if (k == 3'h5 && cnt < (1 << n)) begin
			for (int i = 0; i < 8; i++) sum[i] += int'(pix_data[i]);
			cnt++;
		end
		cs = (k == 3'h6 && !cal);
		if (cs) begin
			cal = 1'b1;
			if (cnt < (1 << n)) flt = 8'hFF;
			else begin
				flt = 8'h00;
				for (int i = 0; i < 8; i++) acor[i] = int'(sh[8'h80][7:0]) - (sum[i] >> n);
			end
		end
		// dark slots and the calibrating slot may carry old or new correction
		pv = {pv[0], chk & ~(sh[8'h81][0] & (k == 3'h5 | cs))};
		in_f = in_f | (k == 3'h1);
		in_l = in_l | (k == 3'h3);
		e[91] = in_f & (~dr | sh[8'h81][14]);
		e[90] = in_l & (~dr | sh[8'h81][15]);
		case (k)
			3'h0: e[89:80] = sh[8'h87][9:0];
			3'h5: e[89:80] = sh[8'h84][9:0];
			3'h6: e[89:80] = sh[8'h85][9:0];
			3'h7: e[89:80] = sh[8'h86][9:0];
			default: e[89:80] = {(k == 3'h1) ? `POF_SYNC_FS : (k == 3'h2) ? `POF_SYNC_FE :
				(k == 3'h3) ? `POF_SYNC_LS : `POF_SYNC_LE, sh[8'h83][6:0]};
		endcase
		for (int i = 0; i < 8; i++) begin
			if (sh[8'h81][0]) v = int'(pix_data[i]) + acor[i];
			else if (sh[8'h81][10]) v = int'(pix_data[i]) - int'(sh[8'h81][9:1]);
			else v = int'(pix_data[i]) + int'(sh[8'h81][9:1]);
			v = (v < 0) ? 0 : (v > 1023) ? 1023 : v;
			if (sh[8'h81][13]) v = v >> 2;
			e[i*10 +: 10] = (k == 3'h5 || k == 3'h6) ? 10'(v) : (k == 3'h7) ? pix_data[i] :
				sh[8'h82][9:0];
		end
		pe[0] = e;
		in_f = in_f & (k != 3'h2);
		in_l = in_l & (k != 3'h4);
		k_fs += int'(k == 3'h1);
		k_dark += int'(k == 3'h5);
		k_img += int'(k == 3'h6);
		k_crc += int'(k == 3'h7);
	endtask

	// register write, then idle long enough for the link side to pick it up
	task automatic cfg(input logic [7:0] a, input logic [15:0] wd);
		logic [15:0] m;
		m = (a < 8'h82) ? 16'hFFFF : (a == 8'h83) ? 16'h007F : (a < 8'h88) ? 16'h03FF : 16'h0;
		if (m != 16'h0) sh[a] = wd & m;
		@(posedge mclk); #1;
		reg_addr = a;
		reg_wdata = wd;
		reg_wr = 1'b1;
		@(posedge mclk); #1;
		reg_wr = 1'b0;
		pv = 2'h0;
		repeat (12) slot(3'h0, 1'b0, 1'b0);
	endtask

	task automatic frame(input int rows, input int drows, input int dpix);
		slot(3'h1, 1'b0, 1'b1);
		for (int r = 0; r < rows; r++) begin
			slot(3'h3, r < drows, 1'b1);
			for (int p = 0; p < ((r < drows) ? dpix : 3); p++)
				slot((r < drows) ? 3'h5 : 3'h6, r < drows, 1'b1);
			slot(3'h4, r < drows, 1'b1);
			slot(3'h0, 1'b0, 1'b1);
		end
		slot(3'h7, 1'b0, 1'b1);
		slot(3'h2, 1'b0, 1'b1);
		repeat (3) slot(3'h0, 1'b0, 1'b1);
		repeat (10) @(posedge mclk);
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// whole sequence needs well under 100 us
	initial begin
		#500_000;
		n_mismatch++;
		final_report();
	end

	initial begin
		{rst, ce, seed, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b11, 32'd4991, 26'h0};
		{pix_kind, pix_dark_row, pix_data, pv, in_f, in_l, cal, flt} = '0;
		{n_mismatch, samples_checked, k_fs, k_dark, k_img, k_crc, cnt} = '0;
		sum = '{default:0};
		acor = '{default:0};
		sh = '{`POF_RST_CAL, `POF_RST_FMT, `POF_RST_IDLE, `POF_RST_FRAME, `POF_RST_DARK,
			`POF_RST_IMG, `POF_RST_CRC, `POF_RST_IDMK, 16'h0, 16'h0};
		repeat (20) @(posedge mclk);
		#1 rst = 1'b0;
		for (int a = 8'h80; a <= 8'h8A; a++) reg_chk(8'(a), rexp(8'(a)));
		repeat (8) slot(3'h0, 1'b0, 1'b1);
		// marker codes kept apart from each other and from the frame codes
		for (int a = 8'h82; a <= 8'h8A; a++) begin
			d = 16'($random(seed));
			if (a >= 8'h84 && a <= 8'h87) d[9:7] = (a == 8'h84) ? 3'h0 : (a == 8'h85) ? 3'h3 :
				(a == 8'h86) ? 3'h4 : 3'h7;
			cfg(8'(a), d);
			reg_chk(8'(a), rexp(8'(a)));
		end
		// write with the clock enable low is dropped
		@(posedge mclk); #1;
		{ce, reg_addr, reg_wdata, reg_wr} = {1'b0, 8'h85, 16'h0000, 1'b1};
		@(posedge mclk); #1;
		{ce, reg_wr} = 2'b10;
		reg_chk(8'h85, rexp(8'h85));
		for (int j = 0; j < 6; j++) begin
			d = 16'($random(seed));
			d[0] = 1'b0;
			if (j == 0) d[10:1] = 10'h3FF;
			if (j == 1) d[10:1] = 10'h1FF;
			if (j == 2) d[15:13] = 3'h0;
			if (j == 3) d[13] = 1'b1;
			cfg(8'h81, d);
			frame(3, 1, 2);
		end
		cfg(8'h80, 16'h0140);
		cfg(8'h81, 16'hC001);
		frame(3, 1, 4);
		frame(3, 2, 1);
		reg_chk(8'h88, 16'h0000);
		cfg(8'h80, 16'h0350);
		frame(3, 1, 2);
		reg_chk(8'h88, 16'h00FF);
		cfg(8'h80, {8'h00, 8'($random(seed))});
		frame(2, 1, 1);
		reg_chk(8'h88, 16'h0000);
		`CHK("fs_count", k_fs, n_fs)
		`CHK("dark_count", k_dark, n_dark)
		`CHK("img_count", k_img, n_img)
		`CHK("crc_count", k_crc, n_crc)
		final_report();
	end
endmodule // pixel_output_formatter_bench

`default_nettype wire
